//--- fpdio_daq_model.sv
// Purpose: Far-side acquisition system driving the front-panel pins
// Assumes: Stamp clock bursts at 20 MHz, other pins held at requested levels
// Notes: Stamp clock stands low between bursts
`timescale 1ns/1ps
module fpdio_daq_model
  import fpdio_pkg::*;
(
  input wire fpdio_pins_t req_i,
  input wire logic [7:0] ticks_i,
  input wire logic go_i,
  output fpdio_pins_t pins_o
);
  logic tick_q = 1'b0;
  // ****
  // Burst generator, slow enough for clean sampling
  // ****
  always @(posedge go_i)
  begin
    repeat (ticks_i)
    begin
      #25 tick_q = 1'b1;
      #25 tick_q = 1'b0;
    end
  end
  always_comb
  begin
    pins_o = req_i;
    pins_o.stamp_clk = tick_q;
  end
endmodule

//--- fpdio_monitor.sv
// Purpose: Port-level checker for the front-panel digital I/O block
// Assumes: Shadow copies of config words follow the register writes
// Notes: Delay path is not covered here
`timescale 1ns/1ps
module fpdio_monitor
  import fpdio_pkg::*;
#(
  parameter int CHANNELS = 16
)
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic run_inhibit_in_i,
  input wire logic [CHANNELS-1:0] local_trigger_i,
  input wire logic sync_ready_i,
  input wire logic record_trigger_o,
  input wire logic run_active_o,
  input wire logic run_led_o,
  input wire logic diff_sync_status_out_o,
  input wire logic [CHANNELS-1:0] relay_select_o,
  input wire logic [7:0] debug_out_o
);
  logic [31:0] cfg_q;
  logic [31:0] ctrl_q;
  // ****
  // Shadow registers
  // ****
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cfg_q <= FPDIO_CFG_RESET;
      ctrl_q <= 32'h0;
    end
    else if (wr_i && addr_i == FPDIO_ADDR_CFG)
      cfg_q <= wdata_i;
    else if (wr_i && addr_i == FPDIO_ADDR_CTRL)
      ctrl_q <= wdata_i;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_debug_gated: assert property (!cfg_q[15] && !$past(cfg_q[15]) |-> debug_out_o == 8'h0)
    else $error("debug outputs active while disabled");
  a_unused_bits: assert property (debug_out_o[1] == 1'b0 && debug_out_o[5] == 1'b0)
    else $error("unused debug bits driven");
  a_any_trig: assert property (cfg_q[15] |-> ##1 debug_out_o[6] == $past(|local_trigger_i))
    else $error("trigger OR output wrong");
  a_led_run: assert property (run_led_o == run_active_o)
    else $error("run indicator differs from run state");
  a_sync_out: assert property (diff_sync_status_out_o |-> $past(sync_ready_i) && $past(ctrl_q[0]))
    else $error("sync status without cause");
  a_no_start: assert property ((ctrl_q[0] && run_inhibit_in_i)[*5] |-> !$rose(run_active_o))
    else $error("run started under inhibit");
  a_run_abort: assert property ((ctrl_q[0] && run_inhibit_in_i)[*6] |-> !run_active_o)
    else $error("run kept under inhibit");
  a_relay_load: assert property (wr_i && addr_i == FPDIO_ADDR_RELAY
    |-> ##2 relay_select_o == $past(wdata_i[CHANNELS-1:0], 2))
    else $error("relay select not loaded");
  a_local_rec: assert property (!ctrl_q[2] |-> ##1 record_trigger_o == $past(|local_trigger_i))
    else $error("record trigger not from local OR");
endmodule
bind fpdio_top fpdio_monitor #(.CHANNELS(CHANNELS)) u_mon (.clk_i(clk_i), .resetn_i(resetn_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .run_inhibit_in_i(run_inhibit_in_i),
  .local_trigger_i(local_trigger_i), .sync_ready_i(sync_ready_i),
  .record_trigger_o(record_trigger_o), .run_active_o(run_active_o), .run_led_o(run_led_o),
  .diff_sync_status_out_o(diff_sync_status_out_o), .relay_select_o(relay_select_o),
  .debug_out_o(debug_out_o));

//--- fpdio_pkg.sv
// Purpose: Shared constants and types for the front-panel digital I/O block
// Assumes: 100 MHz module clock
// Notes: Field positions refer to the trigger configuration word
package fpdio_pkg;
  localparam int FPDIO_STAMP_W = 48;
  localparam int FPDIO_CHANNELS = 16;
  localparam int FPDIO_GROUP_LSB = 12;
  localparam int FPDIO_GROUP_MSB = 14;
  localparam int FPDIO_OUT_EN_BIT = 15;
  localparam int FPDIO_CHAN_LSB = 16;
  localparam int FPDIO_CHAN_MSB = 19;
  localparam int FPDIO_TEST_LSB = 20;
  localparam int FPDIO_TEST_MSB = 23;
  localparam logic [2:0] FPDIO_GROUP_TRIG = 3'h0;
  localparam logic [2:0] FPDIO_GROUP_STAT = 3'h1;
  localparam logic [31:0] FPDIO_CFG_RESET = 32'h0000_0000;
  localparam logic [7:0] FPDIO_DELAY_RESET = 8'h00;
  localparam logic [FPDIO_STAMP_W-1:0] FPDIO_STAMP_ZERO = 48'h0000_0000_0000;
  localparam int FPDIO_SYNC_STAGES = 2;
  // Register offsets
  localparam logic [3:0] FPDIO_ADDR_CFG = 4'h0;
  localparam logic [3:0] FPDIO_ADDR_CTRL = 4'h1;
  localparam logic [3:0] FPDIO_ADDR_RELAY = 4'h2;
  localparam logic [3:0] FPDIO_ADDR_DELAY = 4'h3;
  localparam logic [3:0] FPDIO_ADDR_STATUS = 4'h4;
  localparam logic [3:0] FPDIO_ADDR_STAMP_LO = 4'h5;
  localparam logic [3:0] FPDIO_ADDR_STAMP_HI = 4'h6;
  localparam int FPDIO_CTRL_SYNC_EN = 0;
  localparam int FPDIO_CTRL_RUN_REQ = 1;
  localparam int FPDIO_CTRL_EXT_FT_SEL = 2;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } fpdio_bus_t;

  typedef struct packed {
    logic fast_trig;
    logic validation;
    logic inhibit;
    logic stamp_clk;
    logic stamp_clr;
    logic diff_valid;
    logic diff_fast;
  } fpdio_pins_t;
endpackage

//--- fpdio_top.sv
// Purpose: Front-panel digital I/O of a 16-channel pulse-processing module
// Assumes: Single 100 MHz clock, all pin inputs asynchronous
// Notes: Registers on a plain strobe port, read data one cycle after read strobe
`timescale 1ns/1ps
module fpdio_top
  import fpdio_pkg::*;
#(
  parameter int CHANNELS = FPDIO_CHANNELS,
  parameter int STAMP_W = FPDIO_STAMP_W,
  parameter int DELAY_W = 8
)
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic ext_fast_trigger_in_i,
  input wire logic run_inhibit_in_i,
  input wire logic ext_stamp_clock_in_i,
  input wire logic ext_validation_in_i,
  input wire logic ext_stamp_clear_in_i,
  input wire logic diff_validation_in_i,
  input wire logic diff_fast_trigger_in_i,
  input wire logic [CHANNELS-1:0] local_trigger_i,
  input wire logic [CHANNELS-1:0] channel_validation_i,
  input wire logic [CHANNELS-1:0] channel_veto_i,
  input wire logic [CHANNELS-1:0] global_validation_i,
  input wire logic module_memory_full_flag_i,
  input wire logic system_memory_full_flag_i,
  input wire logic [15:0] test_signals_i,
  input wire logic sync_ready_i,
  input wire logic event_trigger_i,
  output logic [STAMP_W-1:0] event_stamp_o,
  output logic record_trigger_o,
  output logic event_valid_o,
  output logic run_active_o,
  output logic run_led_o,
  output logic diff_sync_status_out_o,
  output logic [CHANNELS-1:0] relay_select_o,
  output logic [7:0] debug_out_o
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  fpdio_pins_t pins_raw;
  fpdio_pins_t sync1_reg;
  fpdio_pins_t sync2_reg;
  fpdio_pins_t sync3_reg;
  fpdio_bus_t bus;

  assign pins_raw = '{fast_trig: ext_fast_trigger_in_i, validation: ext_validation_in_i,
                      inhibit: run_inhibit_in_i, stamp_clk: ext_stamp_clock_in_i,
                      stamp_clr: ext_stamp_clear_in_i, diff_valid: diff_validation_in_i,
                      diff_fast: diff_fast_trigger_in_i};
  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // Third stage only feeds edge detect, never the first stage
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end
    else
    begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] cfg_reg;
  logic [2:0] ctrl_reg;
  logic [CHANNELS-1:0] relay_reg;
  logic [DELAY_W-1:0] delay_reg;
  logic [31:0] rdata_next;
  logic [STAMP_W-1:0] stamp_reg;
  logic [STAMP_W-1:0] capt_reg;
  logic run_reg;
  logic abort_reg;

  // Strobe qualified by one register offset
  function automatic logic fpdio_hit(input logic strobe, input logic [3:0] addr,
    input logic [3:0] offset);
    return strobe && (addr == offset);
  endfunction

  wire wr_cfg = fpdio_hit(bus.wr, bus.addr, FPDIO_ADDR_CFG);
  wire wr_ctrl = fpdio_hit(bus.wr, bus.addr, FPDIO_ADDR_CTRL);
  wire wr_relay = fpdio_hit(bus.wr, bus.addr, FPDIO_ADDR_RELAY);
  wire wr_delay = fpdio_hit(bus.wr, bus.addr, FPDIO_ADDR_DELAY);

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cfg_reg <= FPDIO_CFG_RESET;
      ctrl_reg <= 3'h0;
      relay_reg <= '0;
      delay_reg <= DELAY_W'(FPDIO_DELAY_RESET);
    end
    else
    begin
      if (wr_cfg)
        cfg_reg <= bus.wdata;
      if (wr_ctrl)
        ctrl_reg <= bus.wdata[2:0];
      if (wr_relay)
        relay_reg <= bus.wdata[CHANNELS-1:0];
      if (wr_delay)
        delay_reg <= bus.wdata[DELAY_W-1:0];
    end
  end

  // Unmapped addresses read zero
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    case (bus.addr)
      FPDIO_ADDR_CFG: rdata_next = cfg_reg;
      FPDIO_ADDR_CTRL: rdata_next = {29'h0000_0000, ctrl_reg};
      FPDIO_ADDR_RELAY: rdata_next = 32'(relay_reg);
      FPDIO_ADDR_DELAY: rdata_next = 32'(delay_reg);
      FPDIO_ADDR_STATUS: rdata_next = {29'h0000_0000, abort_reg, sync2_reg.inhibit, run_reg};
      FPDIO_ADDR_STAMP_LO: rdata_next = capt_reg[31:0];
      FPDIO_ADDR_STAMP_HI: rdata_next = 32'(capt_reg[STAMP_W-1:32]);
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // External timestamp
  // ****************************************
  // Edge detect at 100 MHz limits usable stamp clock to a few tens of MHz
  wire stamp_edge = sync2_reg.stamp_clk && !sync3_reg.stamp_clk;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      stamp_reg <= FPDIO_STAMP_ZERO;
      capt_reg <= FPDIO_STAMP_ZERO;
    end
    else
    begin
      if (sync2_reg.stamp_clr)
        stamp_reg <= FPDIO_STAMP_ZERO;
      else if (stamp_edge)
        stamp_reg <= stamp_reg + STAMP_W'(1);
      if (event_trigger_i)
        capt_reg <= stamp_reg;
    end
  end

  // ****************************************
  // Run control
  // ****************************************
  typedef enum logic [2:0] {
    FPDIO_IDLE = 3'b001,
    FPDIO_WAIT = 3'b010,
    FPDIO_RUN = 3'b100
  } fpdio_state_t;
  fpdio_state_t state_reg;
  fpdio_state_t state_next;
  wire sync_en = ctrl_reg[FPDIO_CTRL_SYNC_EN];
  wire run_req = ctrl_reg[FPDIO_CTRL_RUN_REQ];
  wire inhibit = sync_en && sync2_reg.inhibit;
  logic abort_next;
  logic run_hold_reg;
  logic run_hold_next;
  // A request left standing after an abort is not a fresh one
  wire run_fresh = run_req && !run_hold_reg;

  always_comb
  begin
    state_next = state_reg;
    abort_next = abort_reg;
    case (state_reg)
      FPDIO_IDLE:
        if (run_fresh)
        begin
          state_next = FPDIO_WAIT;
          abort_next = 1'b0;
        end
      FPDIO_WAIT:
        if (!run_req)
          state_next = FPDIO_IDLE;
        else if (!inhibit)
          state_next = FPDIO_RUN;
      FPDIO_RUN:
        if (!run_req)
          state_next = FPDIO_IDLE;
        else if (inhibit)
        begin
          state_next = FPDIO_IDLE;
          abort_next = 1'b1;
        end
      default: state_next = FPDIO_IDLE;
    endcase
  end

  // Aborted run stays idle until software drops and renews the request,
  // so an inhibit that falls again cannot restart a run on its own
  assign run_hold_next = run_req && (run_hold_reg || (abort_next && !abort_reg));

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_reg <= FPDIO_IDLE;
      abort_reg <= 1'b0;
      run_hold_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      abort_reg <= abort_next;
      run_hold_reg <= run_hold_next;
    end
  end
  assign run_reg = (state_reg == FPDIO_RUN);

  // ****************************************
  // Trigger path and debug outputs
  // ****************************************
  wire ext_fast = sync2_reg.fast_trig || sync2_reg.diff_fast;
  wire ext_valid = sync2_reg.validation || sync2_reg.diff_valid;
  wire ext_ft_sel = ctrl_reg[FPDIO_CTRL_EXT_FT_SEL];
  wire [3:0] chan = cfg_reg[FPDIO_CHAN_MSB:FPDIO_CHAN_LSB];
  wire [3:0] tsel = cfg_reg[FPDIO_TEST_MSB:FPDIO_TEST_LSB];
  wire [2:0] group = cfg_reg[FPDIO_GROUP_MSB:FPDIO_GROUP_LSB];
  wire out_en = cfg_reg[FPDIO_OUT_EN_BIT];

  // Delay line of the selected channel's local trigger
  logic [(1<<DELAY_W)-1:0] dline_reg;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      dline_reg <= '0;
    else
      dline_reg <= {dline_reg[(1<<DELAY_W)-2:0], local_trigger_i[chan]};
  end
  wire trig_delayed = (delay_reg == '0) ? local_trigger_i[chan] : dline_reg[delay_reg - 1'b1];

  logic [7:0] debug_next;
  always_comb
  begin
    debug_next = 8'h00;
    debug_next[0] = trig_delayed;
    if (group == FPDIO_GROUP_STAT)
    begin
      debug_next[2] = channel_veto_i[chan];
      debug_next[3] = module_memory_full_flag_i;
      debug_next[4] = system_memory_full_flag_i;
    end
    else
    begin
      debug_next[2] = trig_delayed && ext_valid;
      debug_next[3] = global_validation_i[chan];
      debug_next[4] = channel_validation_i[chan];
    end
    debug_next[6] = |local_trigger_i;
    debug_next[7] = test_signals_i[tsel];
    if (!out_en)
      debug_next = 8'h00;
  end

  // Bus, stamp and relay outputs
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rdata_o <= 32'h0000_0000;
      event_stamp_o <= FPDIO_STAMP_ZERO;
      relay_select_o <= '0;
    end
    else
    begin
      rdata_o <= bus.rd ? rdata_next : 32'h0000_0000;
      event_stamp_o <= capt_reg;
      relay_select_o <= relay_reg;
    end
  end

  // Run state outputs
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      run_active_o <= 1'b0;
      run_led_o <= 1'b0;
      diff_sync_status_out_o <= 1'b0;
    end
    else
    begin
      run_active_o <= run_reg;
      run_led_o <= run_reg;
      diff_sync_status_out_o <= sync_en && sync_ready_i && !run_reg;
    end
  end

  // Trigger and debug outputs
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      record_trigger_o <= 1'b0;
      event_valid_o <= 1'b0;
      debug_out_o <= 8'h00;
    end
    else
    begin
      record_trigger_o <= ext_ft_sel ? ext_fast : (|local_trigger_i);
      event_valid_o <= ext_valid;
      debug_out_o <= debug_next;
    end
  end
endmodule

//--- tb.sv
// Purpose: Self-checking bench for the front-panel digital I/O block
// Assumes: Outputs sampled at the edge, before that edge's updates land
// Notes: Delay length path checked with one pulse on the selected channel
`timescale 1ns/1ps
module tb;
  import fpdio_pkg::*;
  logic clk_i, resetn_i, wr_i, rd_i, mf, sf, sr, et, go, rec, val, run, led, sync;
  logic [3:0] addr_i;
  logic [31:0] wdata_i, rdata_o, d;
  logic [15:0] lt, cv, vt, gv, ts, rly;
  logic [7:0] ticks, dbg;
  logic [47:0] stamp;
  fpdio_pins_t req, pins;
  int error_cnt = 0;
  int checks_done = 0;
  int cycles = 0;
  fpdio_daq_model far (.req_i(req), .ticks_i(ticks), .go_i(go), .pins_o(pins));
  fpdio_top dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_fast_trigger_in_i(pins.fast_trig),
    .run_inhibit_in_i(pins.inhibit), .ext_stamp_clock_in_i(pins.stamp_clk),
    .ext_validation_in_i(pins.validation), .ext_stamp_clear_in_i(pins.stamp_clr),
    .diff_validation_in_i(pins.diff_valid), .diff_fast_trigger_in_i(pins.diff_fast),
    .local_trigger_i(lt), .channel_validation_i(cv), .channel_veto_i(vt),
    .global_validation_i(gv), .module_memory_full_flag_i(mf), .system_memory_full_flag_i(sf),
    .test_signals_i(ts), .sync_ready_i(sr), .event_trigger_i(et), .event_stamp_o(stamp),
    .record_trigger_o(rec), .event_valid_o(val), .run_active_o(run), .run_led_o(led),
    .diff_sync_status_out_o(sync), .relay_select_o(rly), .debug_out_o(dbg));
  // ****
  // Shared tasks
  // ****
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(input string n, input logic [47:0] e, input logic [47:0] s);
    checks_done++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    cyc(1);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    cyc(1);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    cyc(1);
    addr_i <= a;
    rd_i <= 1'b1;
    cyc(1);
    rd_i <= 1'b0;
    cyc(1);
    d = rdata_o;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_regs;
    rd(FPDIO_ADDR_CFG);
    chk("cfg reset", FPDIO_CFG_RESET, d);
    wr(4'h9, 32'hFFFF_FFFF);
    rd(4'h9);
    chk("unmapped", 48'h0, d);
    wr(FPDIO_ADDR_RELAY, 32'h0000_A5C3);
    cyc(2);
    chk("relay", 48'hA5C3, rly);
    $display("regs test done");
  endtask
  task automatic t_stamp;
    ticks <= 8'h25;
    go <= 1'b1;
    cyc(200);
    et <= 1'b1;
    cyc(1);
    et <= 1'b0;
    cyc(4);
    chk("stamp port", 48'h25, stamp);
    rd(FPDIO_ADDR_STAMP_LO);
    chk("stamp low", 48'h25, d);
    rd(FPDIO_ADDR_STAMP_HI);
    chk("stamp high", 48'h0, d);
    req.stamp_clr <= 1'b1;
    cyc(5);
    et <= 1'b1;
    cyc(1);
    et <= 1'b0;
    cyc(4);
    chk("stamp cleared", 48'h0, stamp);
    req.stamp_clr <= 1'b0;
    $display("stamp test done");
  endtask
  task automatic t_run;
    req.inhibit <= 1'b1;
    sr <= 1'b1;
    wr(FPDIO_ADDR_CTRL, 32'h3);
    cyc(8);
    chk("held run", 48'h0, run);
    chk("sync out", 48'h1, sync);
    req.inhibit <= 1'b0;
    cyc(8);
    chk("run", 48'h1, run);
    chk("led", 48'h1, led);
    chk("sync in run", 48'h0, sync);
    req.inhibit <= 1'b1;
    cyc(8);
    chk("aborted run", 48'h0, run);
    rd(FPDIO_ADDR_STATUS);
    chk("abort flag", 48'h1, d[2]);
    wr(FPDIO_ADDR_CTRL, 32'h0);
    req.inhibit <= 1'b0;
    $display("run test done");
  endtask
  task automatic t_trig;
    wr(FPDIO_ADDR_CTRL, 32'h4);
    for (int i = 0; i < 2; i++)
    begin
      req.fast_trig <= (i == 0);
      req.diff_fast <= (i == 1);
      req.validation <= (i == 1);
      req.diff_valid <= (i == 0);
      cyc(5);
      chk("ext record", 48'h1, rec);
      chk("ext valid", 48'h1, val);
    end
    req <= '0;
    lt <= 16'h0100;
    cyc(5);
    chk("local masked", 48'h0, rec);
    wr(FPDIO_ADDR_CTRL, 32'h0);
    cyc(3);
    chk("local record", 48'h1, rec);
    $display("trigger test done");
  endtask
  task automatic t_debug;
    logic [31:0] cfg [4] = '{32'h0095_8000, 32'h0095_9000, 32'h0034_9000, 32'h0095_1000};
    logic [7:0] msk [4] = '{8'hFF, 8'hDD, 8'hDD, 8'hFF};
    logic [7:0] exv [4] = '{8'hD9, 8'hCD, 8'h48, 8'h00};
    lt <= 16'h0020;
    cv <= 16'h0020;
    gv <= 16'h0020;
    vt <= 16'h0020;
    mf <= 1'b1;
    ts <= 16'h0200;
    for (int i = 0; i < 4; i++)
    begin
      wr(FPDIO_ADDR_CFG, cfg[i]);
      cyc(6);
      chk("debug", exv[i], dbg & msk[i]);
    end
    $display("debug test done");
  endtask
  task automatic t_delay;
    lt <= 16'h0000;
    wr(FPDIO_ADDR_DELAY, 32'h0000_0004);
    wr(FPDIO_ADDR_CFG, 32'h0005_8000);
    cyc(3);
    lt <= 16'h0020;
    cyc(1);
    lt <= 16'h0000;
    cyc(4);
    chk("delay early", 48'h0, dbg[0]);
    cyc(1);
    chk("delay hit", 48'h1, dbg[0]);
    cyc(1);
    chk("delay late", 48'h0, dbg[0]);
    $display("delay test done");
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      error_cnt++;
      end_of_test();
    end
  end
  initial
  begin
    {resetn_i, wr_i, rd_i, mf, sf, sr, et, go, addr_i, wdata_i} = '0;
    {lt, cv, vt, gv, ts, ticks} = '0;
    req = '0;
    cyc(12);
    resetn_i <= 1'b1;
    t_regs();
    t_stamp();
    t_run();
    t_trig();
    t_debug();
    t_delay();
    end_of_test();
  end
endmodule
